//--- core/qdt_pkg.sv
package qdt_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_MHZ        = 250;     // System clock rate
   localparam int          XTAL_KHZ       = 32;      // Crystal tick rate
   // Clock cycles per half period of the crystal tick (rounded down)
   localparam int          XTAL_HALF_CYC  = (CLK_MHZ * 1000) / (2 * XTAL_KHZ);
   localparam logic [11:0] XTAL_HALF_LAST = 12'(XTAL_HALF_CYC - 1);

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_TMR = 4;                       // Timers
   localparam int NUM_PWM = 8;                       // PWM tick inputs
   localparam int NUM_SRC = 12;                      // PWM plus four crystal rates

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;        // Per timer control
   localparam logic [7:0] OFS_FIXED  = 8'h04;        // Per timer fixed count
   localparam logic [7:0] OFS_COUNT  = 8'h08;        // Per timer live count
   localparam logic [7:0] OFS_MATCH  = 8'h0c;        // Per timer match value
   localparam logic [7:0] TMR_STRIDE = 8'h10;        // Spacing of timer banks
   localparam logic [7:0] OFS_STATUS = 8'h40;        // Sticky events
   localparam logic [7:0] OFS_MASK   = 8'h44;        // Interrupt mask

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          ST_MATCH_LSB = 4;         // Match events above zero events
   localparam logic [7:0]  CTRL_RST     = 8'h00;
   localparam logic [31:0] FIXED_RST    = 32'h0000_0000;
   localparam logic [31:0] COUNT_RST    = 32'h0000_0000;
   localparam logic [31:0] MATCH_RST    = 32'hffff_ffff;
   localparam logic [7:0]  MASK_RST     = 8'h00;

   // Control word, bits 7..0 from run down to source select
   typedef struct packed {
      logic       run;                               // Counting allowed
      logic       update;                            // Fixed write also loads count
      logic       reload;                            // Reload at zero, else stall
      logic       pol;                               // 0 rising edge, 1 falling edge
      logic [3:0] src;                               // 0-7 PWM, 8-11 crystal rates
   } ctrl_t;

   // Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } wb_req_t;

   // Byte lane merge of a write into a stored word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

endpackage : qdt_pkg

//--- core/timer_tick_sel.sv
`timescale 1ns/100ps

// Picks one tick source and turns its chosen edge into a one-cycle pulse
module timer_tick_sel (
   // Clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_b_in,
   // Source levels and selection
   input  wire logic [qdt_pkg::NUM_SRC-1:0] src_in,
   input  wire logic [3:0]                  sel_in,
   input  wire logic                        pol_in,
   // Tick pulse
   output logic                             tick_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic prev;                                    // Level seen last cycle
   } tick_state_t;

   tick_state_t s_q;                                 // Registered state
   tick_state_t s_d;                                 // Next state
   logic        lvl;                                 // Selected, polarity applied

   // Mux then polarity; codes past the last source read as a quiet low
   always_comb begin
      s_d = s_q;
      if (sel_in < 4'(qdt_pkg::NUM_SRC)) begin
         lvl = src_in[sel_in] ^ pol_in;
      end else begin
         lvl = 1'b0;
      end
      s_d.prev = lvl;
      tick_out = lvl & ~s_q.prev;
   end

   // Register; a source switch may give one spurious tick, accepted
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_TICK_EDGE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      tick_out |=> (s_q.prev == 1'b1) && $past(s_q.prev) == 1'b0)
      else $error("tick without a chosen edge");

endmodule : timer_tick_sel

//--- core/quad_down_counter_timers.sv
`timescale 1ns/100ps

// Summary of operation
// - Four timers, 32-bit fixed and live counts
// - Count down per tick; zero sets status
// - Reload on: fixed copied back, keeps counting
// - Reload off: counter stalls at zero
// - Update on: fixed write also loads counter
// - Polarity picks rising or falling source edge
// - Source: PWM or 32/8/4/1 kHz crystal
// - Counter equal to match raises interrupt
module quad_down_counter_timers (
   // Clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_b_in,
   // Wishbone slave
   input  wire qdt_pkg::wb_req_t            wb_req_in,
   output logic                             wb_ack_out,
   output logic [31:0]                      wb_dat_out,
   // Tick sources
   input  wire logic [qdt_pkg::NUM_PWM-1:0] pwm_in,
   // Interrupt
   output logic                             irq_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                                  ack;    // Bus answer
      logic [31:0]                           dat;    // Read data
      logic                                  irq;    // Interrupt level
      logic [7:0]                            st;     // Sticky events
      logic [7:0]                            mask;   // Interrupt mask
      logic [11:0]                           hcnt;   // Crystal half period count
      logic [5:0]                            half;   // Crystal half periods
      logic [qdt_pkg::NUM_TMR-1:0][7:0]      ctrl;   // Control words
      logic [qdt_pkg::NUM_TMR-1:0][31:0]     fixed;  // Fixed counts
      logic [qdt_pkg::NUM_TMR-1:0][31:0]     cnt;    // Live counters
      logic [qdt_pkg::NUM_TMR-1:0][31:0]     match;  // Match values
   } qdt_state_t;

   qdt_state_t                      s_q;             // Registered state
   qdt_state_t                      s_d;             // Next state
   logic [qdt_pkg::NUM_SRC-1:0]     src;             // All tick source levels
   logic [qdt_pkg::NUM_TMR-1:0]     tick;            // Per timer tick pulses
   logic                            req;             // Request present
   logic                            acc;             // Request completes now
   logic                            wr;              // Write takes effect now
   logic                            rd_st;           // Status read completes now
   logic [7:0]                      clr;             // Status bits cleared now
   logic [7:0]                      ev;              // Events this cycle

   // ----------------------------------------------------------------
   // Tick sources
   // ----------------------------------------------------------------
   // One shared divider feeds all rates, so they never drift apart
   // Half period bit 0 is 32 kHz, bit 2 is 8 kHz, bit 3 is 4 kHz, bit 5 is 1 kHz
   assign src = {s_q.half[5], s_q.half[3], s_q.half[2], s_q.half[0], pwm_in};

   // One selector per timer
   // Switching source while running may give one stray tick
   for (genvar t = 0; t < qdt_pkg::NUM_TMR; t++) begin : g_tick
      qdt_pkg::ctrl_t c;                             // Control view
      assign c = qdt_pkg::ctrl_t'(s_q.ctrl[t]);
      timer_tick_sel u_sel (
         .ref_clk_in (ref_clk_in),
         .rst_b_in   (rst_b_in),
         .src_in     (src),
         .sel_in     (c.src),
         .pol_in     (c.pol),
         .tick_out   (tick[t])
      );
   end

   // ----------------------------------------------------------------
   // Bus strobes
   // ----------------------------------------------------------------
   // Answer one cycle after the request; act at the edge that sees ack
   assign req   = wb_req_in.cyc & wb_req_in.stb;
   assign acc   = req & s_q.ack;
   assign wr    = acc & wb_req_in.we;
   assign rd_st = acc & ~wb_req_in.we & (wb_req_in.adr == qdt_pkg::OFS_STATUS);
   // A read clears only the bits it returned, so later events survive; a status write clears the bits written as ones
   assign clr   = rd_st ? s_q.dat[7:0] : (wr && wb_req_in.adr == qdt_pkg::OFS_STATUS) ?
                  wb_req_in.dat[7:0] : 8'h00;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0]    nxt;                           // Counter candidate
      logic           load;                          // Counter written this cycle
      qdt_pkg::ctrl_t c;                             // Control view
      nxt  = '0;
      load = 1'b0;
      c    = '0;
      s_d  = s_q;
      ev   = 8'h00;

      // Crystal divider; free running so all rates stay in phase
      if (s_q.hcnt == qdt_pkg::XTAL_HALF_LAST) begin
         s_d.hcnt = 12'h000;
         s_d.half = s_q.half + 6'h01;
      end else begin
         s_d.hcnt = s_q.hcnt + 12'h001;
      end

      // Bus answer and read data capture
      s_d.ack = req & ~s_q.ack;
      if (req && !s_q.ack) begin
         s_d.dat = 32'h0000_0000;                    // Unmapped reads zero
         if (wb_req_in.adr == qdt_pkg::OFS_STATUS) begin
            s_d.dat = {24'h000000, s_q.st};
         end else if (wb_req_in.adr == qdt_pkg::OFS_MASK) begin
            s_d.dat = {24'h000000, s_q.mask};
         end else if (wb_req_in.adr < qdt_pkg::OFS_STATUS) begin
            case (wb_req_in.adr[3:0])
               qdt_pkg::OFS_CTRL[3:0]: begin
                  s_d.dat = {24'h000000, s_q.ctrl[wb_req_in.adr[5:4]]};
               end
               qdt_pkg::OFS_FIXED[3:0]: begin
                  s_d.dat = s_q.fixed[wb_req_in.adr[5:4]];
               end
               qdt_pkg::OFS_COUNT[3:0]: begin
                  s_d.dat = s_q.cnt[wb_req_in.adr[5:4]];
               end
               qdt_pkg::OFS_MATCH[3:0]: begin
                  s_d.dat = s_q.match[wb_req_in.adr[5:4]];
               end
               default: begin
                  s_d.dat = 32'h0000_0000;           // Not word aligned
               end
            endcase
         end
      end

      // Mask write
      if (wr && wb_req_in.adr == qdt_pkg::OFS_MASK && wb_req_in.sel[0]) begin
         s_d.mask = wb_req_in.dat[7:0];
      end

      // Timers
      for (int t = 0; t < qdt_pkg::NUM_TMR; t++) begin
         c    = qdt_pkg::ctrl_t'(s_q.ctrl[t]);
         nxt  = s_q.cnt[t];
         load = 1'b0;
         // Register writes to this bank
         if (wr && wb_req_in.adr < qdt_pkg::OFS_STATUS && wb_req_in.adr[5:4] == 2'(t)) begin
            case (wb_req_in.adr[3:0])
               qdt_pkg::OFS_CTRL[3:0]: begin
                  if (wb_req_in.sel[0]) begin
                     s_d.ctrl[t] = wb_req_in.dat[7:0];
                  end
               end
               qdt_pkg::OFS_FIXED[3:0]: begin
                  s_d.fixed[t] = qdt_pkg::merge_bytes(s_q.fixed[t], wb_req_in.dat,
                                                      wb_req_in.sel);
                  if (c.update) begin
                     nxt  = s_d.fixed[t];
                     load = 1'b1;
                  end
               end
               qdt_pkg::OFS_MATCH[3:0]: begin
                  s_d.match[t] = qdt_pkg::merge_bytes(s_q.match[t], wb_req_in.dat,
                                                      wb_req_in.sel);
               end
               default: begin
                  load = 1'b0;                       // Live count is read only
               end
            endcase
         end
         // Counting; a load in the same cycle takes priority over the tick
         if (!load && c.run && tick[t]) begin
            if (s_q.cnt[t] > 32'h0000_0001) begin
               nxt = s_q.cnt[t] - 32'h0000_0001;
            end else begin
               if (s_q.cnt[t] == 32'h0000_0001) begin
                  ev[t] = 1'b1;
               end
               nxt = c.reload ? s_q.fixed[t] : 32'h0000_0000;
            end
            load = 1'b1;
         end
         // Match is judged only on a change, so a held value fires once
         if (load && nxt == s_q.match[t] && nxt != s_q.cnt[t]) begin
            ev[qdt_pkg::ST_MATCH_LSB + t] = 1'b1;
         end
         s_d.cnt[t] = nxt;
      end

      // Sticky status, a new event wins over a clear in the same cycle
      s_d.st  = (s_q.st & ~clr) | ev;
      s_d.irq = |(s_d.st & s_d.mask);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // One register for the whole state; mask and bank reset values come from the package, the rest reset to zero
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q      <= '0;
         s_q.mask <= qdt_pkg::MASK_RST;
         for (int t = 0; t < qdt_pkg::NUM_TMR; t++) begin
            s_q.ctrl[t]  <= qdt_pkg::CTRL_RST;
            s_q.fixed[t] <= qdt_pkg::FIXED_RST;
            s_q.cnt[t]   <= qdt_pkg::COUNT_RST;
            s_q.match[t] <= qdt_pkg::MATCH_RST;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign wb_ack_out = s_q.ack;
   assign wb_dat_out = s_q.dat;
   assign irq_out    = s_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // All checks run on the system clock and sleep through reset
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Timer 0 stands in for all four; the banks share one code path
   logic wr_fix0;                                    // Full word write of timer 0 fixed
   logic run0;                                       // Timer 0 counts on a tick
   assign wr_fix0 = wr && wb_req_in.adr == qdt_pkg::OFS_FIXED && wb_req_in.sel == 4'hf;
   assign run0    = s_q.ctrl[0][7] && tick[0] && !wr_fix0;
   logic wr_mask;                                    // Mask write takes effect now
   assign wr_mask = wr && wb_req_in.adr == qdt_pkg::OFS_MASK;

   AST_FIXED_STORE: assert property (wr_fix0 |=> s_q.fixed[0] == $past(wb_req_in.dat))
      else $error("fixed count not stored");
   // Counting path of timer 0
   AST_COUNT_DOWN: assert property (run0 && s_q.cnt[0] > 32'h1 |=>
      s_q.cnt[0] == $past(s_q.cnt[0]) - 32'h1)
      else $error("counter did not decrement");
   AST_ZERO_EVENT: assert property (run0 && s_q.cnt[0] == 32'h1 |=> s_q.st[0])
      else $error("zero status not set");
   AST_RELOAD: assert property (run0 && s_q.cnt[0] == 32'h1 && s_q.ctrl[0][5] |=>
      s_q.cnt[0] == $past(s_q.fixed[0]))
      else $error("fixed count not reloaded");
   // Without reload zero is a dead end until software loads a new value
   AST_STALL: assert property (s_q.cnt[0] == 32'h0 && !s_q.ctrl[0][5] && !wr_fix0 |=>
      s_q.cnt[0] == 32'h0)
      else $error("counter left zero without reload");
   AST_UPDATE_LOAD: assert property (wr_fix0 && s_q.ctrl[0][6] |=>
      s_q.cnt[0] == $past(wb_req_in.dat))
      else $error("fixed write did not load counter");
   // Divider wraps and steps the half period count together
   AST_XTAL_STEP: assert property (s_q.hcnt == qdt_pkg::XTAL_HALF_LAST |=>
      s_q.half == $past(s_q.half) + 6'h1 && s_q.hcnt == 12'h0)
      else $error("crystal divider step wrong");
   // Match fires when the counter arrives at the value, not while it sits
   AST_MATCH_EVENT: assert property (s_q.cnt[0] != $past(s_q.cnt[0]) &&
      s_q.cnt[0] == $past(s_q.match[0]) && $past(s_q.match[0]) == s_q.match[0] |->
      s_q.st[qdt_pkg::ST_MATCH_LSB])
      else $error("match status not set");

   // Sticky status and interrupt
   AST_STATUS_HOLD: assert property (s_q.st[0] && !clr[0] |=> s_q.st[0])
      else $error("status bit lost without a clear");
   // A mask write in the same cycle may drop the line, so it is excluded
   AST_IRQ_LEVEL: assert property (s_q.st[0] && s_q.mask[0] && !clr[0] && !wr_mask |=>
      irq_out)
      else $error("interrupt dropped while status set");
   // Interrupt line always follows status and mask
   AST_IRQ_FOLLOW: assert property (irq_out == |(s_q.st & s_q.mask))
      else $error("interrupt line out of step with status");
   // A fresh event beats a clear in the same cycle
   AST_SET_WINS: assert property (ev[0] && clr[0] |=> s_q.st[0])
      else $error("event lost to a clear");

   // Ack is a single pulse; a request held past it is answered again two cycles later
   AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   // Every new request is answered on the next edge
   AST_ACK_ANSWER: assert property (req && !wb_ack_out |=> wb_ack_out)
      else $error("request not answered in one cycle");
   // Status read returns the bits as they stood when the request came
   AST_STATUS_READ: assert property (req && !wb_ack_out && !wb_req_in.we &&
      wb_req_in.adr == qdt_pkg::OFS_STATUS |=> wb_dat_out == {24'h000000, $past(s_q.st)})
      else $error("status read data wrong");
   // Stalled at zero stays silent: no second zero event
   AST_STALL_QUIET: assert property (run0 && s_q.cnt[0] == 32'h0 |-> !ev[0])
      else $error("zero event raised while stalled");

   // Scenarios the bench should reach
   COV_ZERO: cover property (s_q.st[0] && s_q.ctrl[0][5]);
   COV_RELOAD_WRAP: cover property (run0 && s_q.cnt[0] == 32'h1 && s_q.ctrl[0][5]);
   COV_STALL: cover property (run0 && s_q.cnt[0] == 32'h1 && !s_q.ctrl[0][5]);
   COV_MATCH: cover property (s_q.st[qdt_pkg::ST_MATCH_LSB]);
   COV_IRQ_CLEAR: cover property (irq_out ##1 rd_st ##1 !irq_out);

endmodule : quad_down_counter_timers

//--- tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   // ---------------------------------------------------------------
   // Bench signals
   // ---------------------------------------------------------------
   logic             ref_clk_in;   // 250 MHz clock
   logic             rst_b_in;     // Reset, active low
   qdt_pkg::wb_req_t wb_req;       // Bus request to the block
   logic             wb_ack;       // Bus acknowledge
   logic [31:0]      wb_dat;       // Read data
   logic [7:0]       pwm;          // PWM tick source levels
   logic             irq;          // Interrupt line
   int               error_cnt;    // Mismatches
   int               tests_run;    // Comparisons
   int               cyc_cnt;      // Watchdog cycle count
   logic [31:0]      rd;           // Last read word
   logic [31:0]      n;            // Fixed count of the timer under test
   logic [7:0]       b;            // Bank base of the timer under test
   logic [3:0]       src;          // Source of the timer under test
   logic             pol;          // Edge choice of the timer under test

   // ---------------------------------------------------------------
   // Device under test
   // ---------------------------------------------------------------
   quad_down_counter_timers u_dut (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .wb_req_in  (wb_req),
      .wb_ack_out (wb_ack),
      .wb_dat_out (wb_dat),
      .pwm_in     (pwm),
      .irq_out    (irq)
   );

   // Free running clock, 4 ns period
   initial begin
      ref_clk_in = 1'b0;
      forever #2 ref_clk_in = ~ref_clk_in;
   end

   // Watchdog, sized well above the crystal wait plus register traffic
   always @(posedge ref_clk_in) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 60000) begin
         error_cnt = error_cnt + 1;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Tasks and expectation functions
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One classic cycle; request held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat);
      @(posedge ref_clk_in);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wdat};
      // No timeout here; if ack never comes only the watchdog ends this wait
      do begin
         @(posedge ref_clk_in);
      end while (wb_ack !== 1'b1);
      rd = wb_dat;
      wb_req <= '0;
      @(posedge ref_clk_in);
   endtask : wb_xfer

   task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 32'h0);
      check(what, rd, exp);
   endtask : rd_chk

   // Level change on one source, then let the tick settle
   task automatic pwm_set(input logic [3:0] s, input logic v);
      @(posedge ref_clk_in);
      pwm[s[2:0]] <= v;
      repeat (4) @(posedge ref_clk_in);
   endtask : pwm_set

   // Full pulses: one rising and one falling edge each
   task automatic pulses(input logic [3:0] s, input int k);
      for (int i = 0; i < k; i++) begin
         pwm_set(s, 1'b1);
         pwm_set(s, 1'b0);
      end
   endtask : pulses

   task automatic irq_chk(input logic exp);
      repeat (3) @(posedge ref_clk_in);
      check("irq", {31'h0, irq}, {31'h0, exp});
   endtask : irq_chk

   function automatic logic [31:0] ctrl_w(input logic run, input logic upd, input logic rl,
                                          input logic p, input logic [3:0] s);
      return {24'h0, run, upd, rl, p, s};
   endfunction : ctrl_w

   // Counter value after k ticks from c
   function automatic logic [31:0] after_ticks(input logic [31:0] c, input logic [31:0] f,
                                               input logic rl, input int k);
      for (int i = 0; i < k; i++) begin
         if (c > 32'h1) begin
            c = c - 32'h1;
         end else begin
            c = rl ? f : 32'h0;
         end
      end
      return c;
   endfunction : after_ticks

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_b_in  = 1'b0;
      wb_req    = '0;
      pwm       = '0;
      error_cnt = 0;
      tests_run = 0;
      cyc_cnt   = 0;
      rd        = '0;
      void'($urandom(40));
      repeat (5) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      irq_chk(1'b0);
      // Reset contents of every bank
      for (int t = 0; t < 4; t++) begin
         b = 8'(t * 16);
         rd_chk("ctrl", b + qdt_pkg::OFS_CTRL, 32'h0);
         rd_chk("fixed", b + qdt_pkg::OFS_FIXED, 32'h0);
         rd_chk("count", b + qdt_pkg::OFS_COUNT, 32'h0);
         rd_chk("match", b + qdt_pkg::OFS_MATCH, 32'hffff_ffff);
      end
      rd_chk("status", qdt_pkg::OFS_STATUS, 32'h0);
      rd_chk("mask", qdt_pkg::OFS_MASK, 32'h0);
      wb_xfer(1'b1, 8'h50, 32'hffff_ffff);
      rd_chk("unmapped", 8'h50, 32'h0);
      wb_xfer(1'b1, qdt_pkg::OFS_COUNT, 32'h1234_5678);
      rd_chk("count read only", qdt_pkg::OFS_COUNT, 32'h0);
      // Each timer on its own PWM source, alternating edge choice
      for (int t = 0; t < 4; t++) begin
         b   = 8'(t * 16);
         src = 4'(t * 2);
         pol = t[0];
         n   = 32'd6 + ($urandom % 32'd10);
         // Edge choice set while stopped, so a tick from its flip is not counted
         wb_xfer(1'b1, b + qdt_pkg::OFS_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, pol, src));
         wb_xfer(1'b1, b + qdt_pkg::OFS_FIXED, n);
         rd_chk("count no update", b + qdt_pkg::OFS_COUNT, 32'h0);
         wb_xfer(1'b1, b + qdt_pkg::OFS_CTRL, ctrl_w(1'b1, 1'b1, 1'b0, pol, src));
         wb_xfer(1'b1, b + qdt_pkg::OFS_FIXED, n);
         rd_chk("count update", b + qdt_pkg::OFS_COUNT, n);
         wb_xfer(1'b1, b + qdt_pkg::OFS_MATCH, n - 32'h2);
         pwm_set(src, 1'b1);
         rd_chk("count rise", b + qdt_pkg::OFS_COUNT, pol ? n : n - 32'h1);
         pwm_set(src, 1'b0);
         rd_chk("count fall", b + qdt_pkg::OFS_COUNT, n - 32'h1);
         pulses(src, 1);
         rd_chk("status match", qdt_pkg::OFS_STATUS, 32'h1 << (4 + t));
         rd_chk("status cleared", qdt_pkg::OFS_STATUS, 32'h0);
         // Run past zero with reload off
         pulses(src, int'(n) + 1);
         rd_chk("count stall", b + qdt_pkg::OFS_COUNT, after_ticks(n - 32'h2, n, 1'b0,
                int'(n) + 1));
         irq_chk(1'b0);
         wb_xfer(1'b1, qdt_pkg::OFS_MASK, 32'h1 << t);
         irq_chk(1'b1);
         repeat (20) @(posedge ref_clk_in);
         irq_chk(1'b1);
         rd_chk("status zero", qdt_pkg::OFS_STATUS, 32'h1 << t);
         irq_chk(1'b0);
         // Reload on: from zero, wrap once more
         wb_xfer(1'b1, b + qdt_pkg::OFS_CTRL, ctrl_w(1'b1, 1'b0, 1'b1, pol, src));
         pulses(src, int'(n) + 2);
         rd_chk("count reload", b + qdt_pkg::OFS_COUNT, after_ticks(32'h0, n, 1'b1,
                int'(n) + 2));
         irq_chk(1'b1);
         rd_chk("status reload", qdt_pkg::OFS_STATUS, (32'h1 << t) | (32'h1 << (4 + t)));
         wb_xfer(1'b1, b + qdt_pkg::OFS_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, pol, src));
         wb_xfer(1'b1, qdt_pkg::OFS_MASK, 32'h0);
      end
      // Timer 1 on 8 kHz starts first, so its window spans over one period
      wb_xfer(1'b1, 8'h10 + qdt_pkg::OFS_CTRL, ctrl_w(1'b1, 1'b1, 1'b0, 1'b0, 4'h9));
      wb_xfer(1'b1, 8'h10 + qdt_pkg::OFS_FIXED, 32'h100);
      // Crystal source at 32 kHz: four periods of 7812 cycles
      wb_xfer(1'b1, qdt_pkg::OFS_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, 1'b0, 4'h8));
      wb_xfer(1'b1, qdt_pkg::OFS_CTRL, ctrl_w(1'b1, 1'b1, 1'b0, 1'b0, 4'h8));
      wb_xfer(1'b1, qdt_pkg::OFS_FIXED, 32'h100);
      repeat (4 * 2 * qdt_pkg::XTAL_HALF_CYC) @(posedge ref_clk_in);
      wb_xfer(1'b0, qdt_pkg::OFS_COUNT, 32'h0);
      check("crystal ticks", {31'h0, rd inside {[32'hfb:32'hfd]}}, 32'h1);
      wb_xfer(1'b0, 8'h10 + qdt_pkg::OFS_COUNT, 32'h0);
      check("crystal 8k ticks", {31'h0, rd inside {[32'hfe:32'hff]}}, 32'h1);
      complete_run();
   end
endmodule : tb_top
